// *** inc/ppo_pkg.sv ***
/*
 * ppo_pkg: register map, reset values and port A pin roles of the
 * port pin override block.
 * assumes a 32-bit APB slave with byte addresses and one word per register.
 */
package ppo_pkg;
	localparam int          NPINS     = 8;
	localparam int          ADDR_W    = 8;
	localparam int          DATA_W    = 32;
	// byte offsets
	localparam logic [7:0]  OFS_PIN   = 8'h00;
	localparam logic [7:0]  OFS_DIR   = 8'h04;
	localparam logic [7:0]  OFS_OUT   = 8'h08;
	localparam logic [7:0]  OFS_PUE   = 8'h0c;
	localparam logic [7:0]  OFS_STAT  = 8'h10;
	// reset values: every pin an input with no pull-up, so the pad floats
	localparam logic [7:0]  RST_DIR   = 8'h00;
	localparam logic [7:0]  RST_OUT   = 8'h00;
	localparam logic [7:0]  RST_PUE   = 8'h00;
	localparam logic [7:0]  RST_SYNC  = 8'h00;
	// status word field positions
	localparam int          STAT_OE   = 0;
	localparam int          STAT_PULL = 8;
	localparam int          STAT_IE   = 16;
	// port A pins with a single-pin alternate role
	localparam int          PA_CMP_POS = 1;
	localparam int          PA_CMP_NEG = 2;
	localparam int          PA_SPI_SEL = 6;
	localparam int          PA_MULTI   = 7;
endpackage

// *** inc/ppo_pin_if.sv ***
/*
 * ppo_pin_if: software bits and override bundle of one port, and the
 * resolved pad controls that come back.
 * assumes one driver per side: ctrl is the port top, pins the resolver.
 */
`timescale 1ns/1ps
interface ppo_pin_if #(parameter int N = 8);
	logic [N-1:0] sw_dir;
	logic [N-1:0] sw_out;
	logic [N-1:0] sw_pue;
	logic [N-1:0] pu_oe;
	logic [N-1:0] pu_ov;
	logic [N-1:0] dd_oe;
	logic [N-1:0] dd_ov;
	logic [N-1:0] pv_oe;
	logic [N-1:0] pv_ov;
	logic [N-1:0] pt_oe;
	logic [N-1:0] ie_oe;
	logic [N-1:0] ie_ov;
	logic [N-1:0] pad_in;
	logic         sleep;
	logic [N-1:0] oe;
	logic [N-1:0] val;
	logic [N-1:0] pull;
	logic [N-1:0] ie;
	logic [N-1:0] di;
	modport ctrl (output sw_dir, sw_out, sw_pue, pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov,
		pt_oe, ie_oe, ie_ov, pad_in, sleep, input oe, val, pull, ie, di);
	modport pins (input sw_dir, sw_out, sw_pue, pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov,
		pt_oe, ie_oe, ie_ov, pad_in, sleep, output oe, val, pull, ie, di);
endinterface // ppo_pin_if

// *** hw/ppo_pin_ovr.sv ***
/*
 * ppo_pin_ovr: per-pin resolution of software bits against the
 * override bundle, purely combinational.
 * assumes the override bundle comes straight from the owning peripherals.
 */
`timescale 1ns/1ps
module ppo_pin_ovr #(
	parameter int N = 8
) (
	ppo_pin_if.pins p // port bundle
);
	function automatic logic [N-1:0] ovr_sel(input logic [N-1:0] en, input logic [N-1:0] ov,
		input logic [N-1:0] dflt);
		return (en & ov) | (~en & dflt);
	endfunction

	wire [N-1:0] lvl_sw;
	wire [N-1:0] lvl_pick;

	// toggle override inverts the stored level, not the register itself
	assign lvl_sw   = p.sw_out ^ p.pt_oe;
	assign lvl_pick = ovr_sel(p.pv_oe, p.pv_ov, lvl_sw);
	assign p.pull   = ovr_sel(p.pu_oe, p.pu_ov, p.sw_pue);
	assign p.oe     = ovr_sel(p.dd_oe, p.dd_ov, p.sw_dir);
	// level gated by the driver enable: an undriven pad shows zero
	assign p.val    = p.oe & lvl_pick;
	assign p.ie     = ovr_sel(p.ie_oe, p.ie_ov, {N{~p.sleep}});
	// clamp applied after the trigger output; no synchroniser here
	assign p.di     = p.pad_in & p.ie;
endmodule // ppo_pin_ovr

// *** hw/ppo_pa_map.sv ***
/*
 * ppo_pa_map: fans port A digital and analog pin lines out to the
 * peripherals that own each alternate role.
 * assumes consumers of the raw digital lines synchronise them themselves.
 */
`timescale 1ns/1ps
module ppo_pa_map (
	input  wire logic [7:0] di,                   // raw clamped digital in
	input  wire logic [7:0] ana,                  // analog pad lines
	output logic      [7:0] pin_change_irq_src,   // pin change group 0
	output logic      [7:0] analog_channel_in,    // converter channels
	output logic            comparator_pos_in,    // comparator +
	output logic            comparator_neg_in,    // comparator -
	output logic            spi_target_sel_in,    // spi select in
	output logic            timer1_capture_in,    // timer 1 capture
	output logic            timer1_ext_count_clk, // timer 1 count clock
	output logic            wire_clk_in,          // two-wire clock in
	output logic            spi_clk_in            // spi clock in
);
	assign pin_change_irq_src   = di;
	assign analog_channel_in    = ana;
	assign comparator_pos_in    = ana[ppo_pkg::PA_CMP_POS];
	assign comparator_neg_in    = ana[ppo_pkg::PA_CMP_NEG];
	assign spi_target_sel_in    = di[ppo_pkg::PA_SPI_SEL];
	// count clock used unsynchronised on purpose: it clocks the timer
	assign timer1_capture_in    = di[ppo_pkg::PA_MULTI];
	assign timer1_ext_count_clk = di[ppo_pkg::PA_MULTI];
	assign wire_clk_in          = di[ppo_pkg::PA_MULTI];
	assign spi_clk_in           = di[ppo_pkg::PA_MULTI];
endmodule // ppo_pa_map

// *** hw/ppo_port_top.sv ***
/*
 * ppo_port_top: port A with alternate-function override, APB register
 * file, input synchroniser and peripheral fan-out.
 * assumes pad_in is the input trigger output, peripherals supply all
 * override bits, and an APB master on pclk.
 */
`timescale 1ns/1ps
module ppo_port_top (
	input  wire logic        pclk,                 // bus clock
	input  wire logic        presetn,              // async reset, low
	input  wire logic        pclken,               // clock enable
	input  wire logic        psel,                 // apb select
	input  wire logic        penable,              // apb enable
	input  wire logic        pwrite,               // apb direction
	input  wire logic [7:0]  paddr,                // apb byte address
	input  wire logic [31:0] pwdata,               // apb write data
	output logic      [31:0] prdata,               // apb read data
	output logic             pready,               // apb ready
	output logic             pslverr,              // apb error
	input  wire logic        sleep_req,            // controller sleep
	input  wire logic [7:0]  pullup_ovr_en,        // pull-up override en
	input  wire logic [7:0]  pullup_ovr_val,       // pull-up override val
	input  wire logic [7:0]  dir_ovr_en,           // direction override en
	input  wire logic [7:0]  dir_ovr_val,          // direction override val
	input  wire logic [7:0]  outval_ovr_en,        // level override en
	input  wire logic [7:0]  outval_ovr_val,       // level override val
	input  wire logic [7:0]  out_invert_ovr_en,    // toggle override en
	input  wire logic [7:0]  in_enable_ovr_en,     // input en override en
	input  wire logic [7:0]  in_enable_ovr_val,    // input en override val
	input  wire logic [7:0]  pad_in,               // trigger outputs
	output logic      [7:0]  pad_out,              // pad level
	output logic      [7:0]  pad_oe,               // pad driver enable
	output logic      [7:0]  pad_pullup,           // pull-up enable
	input  wire logic [7:0]  analog_pad_line_in,   // analog level at pad
	input  wire logic [7:0]  analog_drive_val,     // peripheral analog out
	input  wire logic [7:0]  analog_drive_en,      // peripheral analog en
	output logic      [7:0]  analog_pad_line_out,  // analog onto pad
	output logic      [7:0]  analog_pad_line_oe,   // analog drive enable
	output logic      [7:0]  alt_func_raw_in,      // raw digital in
	output logic      [7:0]  pin_change_irq_src,   // pin change group 0
	output logic      [7:0]  analog_channel_in,    // converter channels
	output logic             comparator_pos_in,    // comparator +
	output logic             comparator_neg_in,    // comparator -
	output logic             spi_target_sel_in,    // spi select in
	output logic             timer1_capture_in,    // timer 1 capture
	output logic             timer1_ext_count_clk, // timer 1 count clock
	output logic             wire_clk_in,          // two-wire clock in
	output logic             spi_clk_in            // spi clock in
);
	localparam int N = ppo_pkg::NPINS;

	logic [N-1:0]  dir_r;
	logic [N-1:0]  out_r;
	logic [N-1:0]  out_nxt;
	logic [N-1:0]  pue_r;
	logic [N-1:0]  meta_r;
	logic [N-1:0]  sync_r;
	logic [31:0]   prdata_r;
	logic [31:0]   rd_nxt;

	wire           setup;
	wire           access;
	wire           wr_en;
	wire           hit_pin;
	wire           hit_dir;
	wire           hit_out;
	wire           hit_pue;
	wire           hit_stat;
	wire           mapped;
	wire           port_write_strobe_pin;
	wire           port_write_strobe_dir;
	wire           port_write_strobe_out;
	wire           port_write_strobe_pue;
	wire [N-1:0]   wdat8;
	wire [31:0]    stat_word;

	ppo_pin_if #(.N(N)) pin_bus ();

	ppo_pin_ovr #(.N(N)) u_pin (
		.p (pin_bus)
	);

	// overrides arrive from their owning peripherals, none made here
	assign pin_bus.pu_oe  = pullup_ovr_en;
	assign pin_bus.pu_ov  = pullup_ovr_val;
	assign pin_bus.dd_oe  = dir_ovr_en;
	assign pin_bus.dd_ov  = dir_ovr_val;
	assign pin_bus.pv_oe  = outval_ovr_en;
	assign pin_bus.pv_ov  = outval_ovr_val;
	assign pin_bus.pt_oe  = out_invert_ovr_en;
	assign pin_bus.ie_oe  = in_enable_ovr_en;
	assign pin_bus.ie_ov  = in_enable_ovr_val;
	assign pin_bus.pad_in = pad_in;
	assign pin_bus.sleep  = sleep_req;
	assign pin_bus.sw_dir = dir_r;
	assign pin_bus.sw_out = out_r;
	assign pin_bus.sw_pue = pue_r;

	assign pad_out         = pin_bus.val;
	assign pad_oe          = pin_bus.oe;
	assign pad_pullup      = pin_bus.pull;
	assign alt_func_raw_in = pin_bus.di;

	// analog path bypasses all digital logic
	assign analog_pad_line_out = analog_drive_val;
	assign analog_pad_line_oe  = analog_drive_en;

	ppo_pa_map u_map (
		.di                   (pin_bus.di),
		.ana                  (analog_pad_line_in),
		.pin_change_irq_src   (pin_change_irq_src),
		.analog_channel_in    (analog_channel_in),
		.comparator_pos_in    (comparator_pos_in),
		.comparator_neg_in    (comparator_neg_in),
		.spi_target_sel_in    (spi_target_sel_in),
		.timer1_capture_in    (timer1_capture_in),
		.timer1_ext_count_clk (timer1_ext_count_clk),
		.wire_clk_in          (wire_clk_in),
		.spi_clk_in           (spi_clk_in)
	);

	// apb decode; a frozen clock stalls the access through pready
	assign setup    = psel & ~penable & pclken;
	assign access   = psel & penable & pclken;
	assign wr_en    = access & pwrite;
	assign hit_pin  = paddr == ppo_pkg::OFS_PIN;
	assign hit_dir  = paddr == ppo_pkg::OFS_DIR;
	assign hit_out  = paddr == ppo_pkg::OFS_OUT;
	assign hit_pue  = paddr == ppo_pkg::OFS_PUE;
	assign hit_stat = paddr == ppo_pkg::OFS_STAT;
	assign mapped   = hit_pin | hit_dir | hit_out | hit_pue | hit_stat;
	assign wdat8    = pwdata[N-1:0];

	// one strobe per writable register, common to every pin of the port
	assign port_write_strobe_pin = wr_en & hit_pin;
	assign port_write_strobe_dir = wr_en & hit_dir;
	assign port_write_strobe_out = wr_en & hit_out;
	assign port_write_strobe_pue = wr_en & hit_pue;

	assign pready  = pclken;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_r;

	assign stat_word = {8'h00, pin_bus.ie, pin_bus.pull, pin_bus.oe};

	// a direct write wins over a toggle write; they never share a cycle
	always_comb begin
		out_nxt = out_r;
		if (port_write_strobe_out) begin
			out_nxt = wdat8;
		end else if (port_write_strobe_pin) begin
			out_nxt = out_r ^ wdat8;
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (1'b1)
			hit_pin: rd_nxt = {24'h00_0000, sync_r};
			hit_dir: rd_nxt = {24'h00_0000, dir_r};
			hit_out: rd_nxt = {24'h00_0000, out_r};
			hit_pue: rd_nxt = {24'h00_0000, pue_r};
			hit_stat: rd_nxt = stat_word;
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r <= ppo_pkg::RST_DIR;
			out_r <= ppo_pkg::RST_OUT;
			pue_r <= ppo_pkg::RST_PUE;
		end else if (pclken) begin
			out_r <= out_nxt;
			if (port_write_strobe_dir) dir_r <= wdat8;
			if (port_write_strobe_pue) pue_r <= wdat8;
		end
	end

	// read data is a snapshot taken at the setup edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup) begin
			prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
		end
	end

	// two-stage synchroniser feeding only the software read path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= ppo_pkg::RST_SYNC;
			sync_r <= ppo_pkg::RST_SYNC;
		end else if (pclken) begin
			meta_r <= pin_bus.di;
			sync_r <= meta_r;
		end
	end

	AST_PULLUP_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		pad_pullup == ((pullup_ovr_en & pullup_ovr_val) | (~pullup_ovr_en & pue_r)))
		else $error("pull-up select wrong");

	AST_PULLUP_OVR: assert property (@(posedge pclk) disable iff (!presetn)
		((pad_pullup ^ pullup_ovr_val) & pullup_ovr_en) == 8'h00)
		else $error("pull-up override ignored");

	AST_DIR_SEL: assert property (@(posedge pclk) disable iff (!presetn)
		(dir_ovr_en == 8'h00) |-> (pad_oe == dir_r))
		else $error("driver enable not from direction bit");

	AST_DIR_OVR: assert property (@(posedge pclk) disable iff (!presetn)
		((pad_oe ^ dir_ovr_val) & dir_ovr_en) == 8'h00)
		else $error("direction override ignored");

	AST_VAL_OVR: assert property (@(posedge pclk) disable iff (!presetn)
		((pad_out ^ outval_ovr_val) & outval_ovr_en & pad_oe) == 8'h00)
		else $error("level override ignored");

	AST_VAL_SW: assert property (@(posedge pclk) disable iff (!presetn)
		((pad_out ^ out_r ^ out_invert_ovr_en) & ~outval_ovr_en & pad_oe) == 8'h00)
		else $error("software level not driven");

	AST_TOGGLE_OVR: assert property (@(posedge pclk) disable iff (!presetn)
		((pad_out ^ (dir_r & ~out_r)) & out_invert_ovr_en & ~outval_ovr_en & ~dir_ovr_en) == 8'h00)
		else $error("toggle override not inverting");

	AST_IN_EN: assert property (@(posedge pclk) disable iff (!presetn)
		(in_enable_ovr_en == 8'h00 && sleep_req) |-> alt_func_raw_in == 8'h00)
		else $error("input not clamped in sleep");

	AST_IN_OVR: assert property (@(posedge pclk) disable iff (!presetn)
		((alt_func_raw_in ^ (pad_in & in_enable_ovr_val)) & in_enable_ovr_en) == 8'h00)
		else $error("input enable override ignored");

	AST_SYNC_LAG: assert property (@(posedge pclk) disable iff (!presetn)
		($past(pclken, 1) && $past(pclken, 2)) |-> sync_r == $past(alt_func_raw_in, 2))
		else $error("read path not two stages behind raw input");

	AST_ANALOG: assert property (@(posedge pclk) disable iff (!presetn)
		analog_channel_in == analog_pad_line_in && analog_pad_line_out == analog_drive_val)
		else $error("analog path not direct");

	AST_PIN_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
		port_write_strobe_pin |=> out_r == ($past(out_r) ^ $past(wdat8)))
		else $error("input register write did not toggle");

	AST_PCINT: assert property (@(posedge pclk) disable iff (!presetn)
		pin_change_irq_src == alt_func_raw_in && comparator_neg_in == analog_pad_line_in[2])
		else $error("pin change or comparator mapping wrong");

	AST_UNDRIVEN: assert property (@(posedge pclk) disable iff (!presetn)
		(pad_out & ~pad_oe) == 8'h00)
		else $error("level shown on undriven pad");

	AST_PLAIN_IO: assert property (@(posedge pclk) disable iff (!presetn)
		(pullup_ovr_en == 8'h00 && dir_ovr_en == 8'h00 && outval_ovr_en == 8'h00
		&& out_invert_ovr_en == 8'h00)
		|-> (pad_pullup == pue_r && pad_out == (dir_r & out_r)))
		else $error("plain io behaviour broken");

	AST_CMP_POS: assert property (@(posedge pclk) disable iff (!presetn)
		comparator_pos_in == analog_pad_line_in[ppo_pkg::PA_CMP_POS])
		else $error("comparator positive input mapping wrong");

	AST_PA_MULTI: assert property (@(posedge pclk) disable iff (!presetn)
		{timer1_capture_in, timer1_ext_count_clk, wire_clk_in, spi_clk_in, spi_target_sel_in}
		== {{4{alt_func_raw_in[ppo_pkg::PA_MULTI]}}, alt_func_raw_in[ppo_pkg::PA_SPI_SEL]})
		else $error("pin 6 or pin 7 role mapping wrong");

	AST_DI_RAW: assert property (@(posedge pclk) disable iff (!presetn)
		alt_func_raw_in == (pad_in & ((in_enable_ovr_en & in_enable_ovr_val)
		| (~in_enable_ovr_en & {8{~sleep_req}}))))
		else $error("raw input enable selection wrong");

	AST_DIR_WR: assert property (@(posedge pclk) disable iff (!presetn)
		port_write_strobe_dir |=> dir_r == $past(wdat8))
		else $error("direction write did not land");

	AST_PUE_WR: assert property (@(posedge pclk) disable iff (!presetn)
		port_write_strobe_pue |=> pue_r == $past(wdat8))
		else $error("pull-up write did not land");
endmodule // ppo_port_top

// *** tb/ppo_pad_model.sv ***
/*
 * ppo_pad_model: pads, external sources and a consuming peripheral around port A.
 * assumes the bench supplies external levels; the wire level is fed back as pad_in.
 */
`timescale 1ns/1ps
module ppo_pad_model (
	input  wire logic       pclk,       // bus clock
	input  wire logic [7:0] pad_out,    // design level
	input  wire logic [7:0] pad_oe,     // design driver enable
	input  wire logic [7:0] pad_pullup, // design pull-up
	input  wire logic [7:0] ext_lvl,    // external level
	input  wire logic [7:0] ext_en,     // external driver present
	input  wire logic [7:0] ana_out,    // peripheral analog drive
	input  wire logic [7:0] ana_oe,     // peripheral analog enable
	input  wire logic [7:0] ana_ext,    // external analog level
	input  wire logic [7:0] raw_in,     // raw digital in
	output logic      [7:0] pad_in,     // wire level at trigger
	output logic      [7:0] ana_in,     // analog level at pad
	output logic      [7:0] raw_sync    // consumer's own copy
);
	logic [7:0] flip_r = 8'h55;
	logic [7:0] s1_r;
	// a floating pad must not look like its last value
	always @(posedge pclk) begin
		flip_r <= ~flip_r;
	end
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_lvl)
		| (~pad_oe & ~ext_en & (pad_pullup | flip_r));
	assign ana_in = (ana_oe & ana_out) | (~ana_oe & ana_ext);
	always @(posedge pclk) begin
		s1_r     <= raw_in;
		raw_sync <= s1_r;
	end
endmodule // ppo_pad_model

// *** tb/ppo_port_top_tb.sv ***
/*
 * ppo_port_top_tb: random override and register traffic on port A, scoreboarded.
 * assumes the design answers APB with pready = pclken and pins are combinational.
 */
`timescale 1ns/1ps
module ppo_port_top_tb;
	logic pclk = 1'b0, presetn = 1'b0, pclken = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, stat_s, wd;
	logic        pready, pslverr, sleep_req = 1'b0, pin_req = 1'b0;
	logic [7:0]  pullup_ovr_en = 8'h00, pullup_ovr_val = 8'h00, dir_ovr_en = 8'h00, dir_ovr_val = 8'h00;
	logic [7:0]  outval_ovr_en = 8'h00, outval_ovr_val = 8'h00, out_invert_ovr_en = 8'h00;
	logic [7:0]  in_enable_ovr_en = 8'h00, in_enable_ovr_val = 8'h00, analog_drive_val = 8'h00;
	logic [7:0]  analog_drive_en = 8'h00, ext_lvl = 8'h00, ext_en = 8'hff, ana_ext = 8'h00;
	logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup, analog_pad_line_in, analog_pad_line_out;
	logic [7:0]  analog_pad_line_oe, alt_func_raw_in, pin_change_irq_src, analog_channel_in;
	logic        comparator_pos_in, comparator_neg_in, spi_target_sel_in, timer1_capture_in;
	logic        timer1_ext_count_clk, wire_clk_in, spi_clk_in;
	logic [7:0]  dir_s = 8'h00, out_s = 8'h00, pue_s = 8'h00, raw_s, raw_cons;
	logic [70:0] obs, e_pin;
	logic [32:0] apb_q[$];
	logic [70:0] pin_q[$];
	int          seed, checked = 0, mismatches = 0;

	always #25 pclk = ~pclk;

	ppo_port_top i_ppo_port_top (.pclk, .presetn, .pclken, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .sleep_req, .pullup_ovr_en, .pullup_ovr_val, .dir_ovr_en,
		.dir_ovr_val, .outval_ovr_en, .outval_ovr_val, .out_invert_ovr_en, .in_enable_ovr_en,
		.in_enable_ovr_val, .pad_in, .pad_out, .pad_oe, .pad_pullup, .analog_pad_line_in,
		.analog_drive_val, .analog_drive_en, .analog_pad_line_out, .analog_pad_line_oe,
		.alt_func_raw_in, .pin_change_irq_src, .analog_channel_in, .comparator_pos_in,
		.comparator_neg_in, .spi_target_sel_in, .timer1_capture_in, .timer1_ext_count_clk,
		.wire_clk_in, .spi_clk_in);

	ppo_pad_model i_ppo_pad_model (.pclk, .pad_out, .pad_oe, .pad_pullup, .ext_lvl, .ext_en,
		.ana_out(analog_pad_line_out), .ana_oe(analog_pad_line_oe), .ana_ext, .raw_in(alt_func_raw_in),
		.pad_in, .ana_in(analog_pad_line_in), .raw_sync(raw_cons));

	assign obs = {pad_oe, pad_out, pad_pullup, alt_func_raw_in, pin_change_irq_src, analog_channel_in,
		analog_pad_line_out, analog_pad_line_oe, comparator_pos_in, comparator_neg_in, spi_target_sel_in,
		timer1_capture_in, timer1_ext_count_clk, wire_clk_in, spi_clk_in};

	task tally_and_finish;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task check(input logic [70:0] seen, input logic [70:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// request held from setup until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		apb_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			tally_and_finish();
		end
		{psel, penable} <= 2'b00;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask

	// peripherals' override bundle, sleep and external pad levels
	task drive_pins(input logic plain);
		logic [7:0] v[15];
		logic [7:0] oe, lvl, pl, ie, wl, an;
		for (int k = 0; k < 15; k++) begin
			v[k] = (plain && k < 9) ? 8'h00 : 8'($random(seed));
		end
		oe = (v[2] & v[3]) | (~v[2] & dir_s);
		lvl = (v[4] & v[5]) | (~v[4] & (out_s ^ v[6]));
		pl = (v[0] & v[1]) | (~v[0] & pue_s);
		ie = (v[7] & v[8]) | (~v[7] & {8{~v[14][0]}});
		v[10] = v[10] | ~pl;
		wl = ((oe & lvl) | (~oe & v[10] & v[9]) | (~oe & ~v[10] & pl)) & ie;
		an = (v[12] & v[13]) | (~v[12] & v[11]);
		{pullup_ovr_en, pullup_ovr_val, dir_ovr_en, dir_ovr_val, outval_ovr_en, outval_ovr_val,
			out_invert_ovr_en, in_enable_ovr_en, in_enable_ovr_val} <= {v[0], v[1], v[2], v[3], v[4],
			v[5], v[6], v[7], v[8]};
		{ext_lvl, ext_en, ana_ext, analog_drive_en, analog_drive_val} <= {v[9], v[10], v[11], v[12], v[13]};
		sleep_req <= v[14][0];
		pin_q.push_back({oe, oe & lvl, pl, wl, wl, an, v[13], v[12], an[1], an[2], wl[6], {4{wl[7]}}});
		raw_s = wl;
		stat_s = {8'h00, ie, pl, oe};
		pin_req <= 1'b1;
		@(posedge pclk);
		pin_req <= 1'b0;
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			check(71'({pslverr, pwrite ? 32'h0 : prdata}), 71'(apb_q.pop_front()));
		end
	end

	always @(negedge pclk) begin
		if (pin_req) begin
			e_pin = pin_q.pop_front();
			check(71'(obs[70:47]), 71'(e_pin[70:47]));
			check(71'(obs[46:0]), 71'(e_pin[46:0]));
		end
	end

	initial begin
		seed = 90886;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		drive_pins(1'b1);
		rd(ppo_pkg::OFS_DIR, 32'h0);
		rd(ppo_pkg::OFS_OUT, 32'h0);
		rd(ppo_pkg::OFS_PUE, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 40; i++) begin
			wd = $random(seed);
			// upper bits of the word are write-ignored
			dir_s = (i == 1) ? wd[7:0] & 8'hf9 : wd[7:0];
			apb(1'b1, ppo_pkg::OFS_DIR, {wd[31:8], dir_s}, 33'h0);
			wd = $random(seed);
			out_s = wd[7:0];
			apb(1'b1, ppo_pkg::OFS_OUT, wd, 33'h0);
			wd = $random(seed);
			pue_s = (i == 1) ? wd[7:0] & 8'hf9 : wd[7:0];
			apb(1'b1, ppo_pkg::OFS_PUE, {wd[31:8], pue_s}, 33'h0);
			drive_pins(i % 4 == 0);
			rd(ppo_pkg::OFS_PIN, {24'h0, raw_s});
			check(71'(raw_cons), 71'(raw_s));
			rd(ppo_pkg::OFS_STAT, stat_s);
			rd(ppo_pkg::OFS_DIR, {24'h0, dir_s});
		end
		$display("test override sweep done");
		wd = $random(seed);
		out_s = out_s ^ wd[7:0];
		apb(1'b1, ppo_pkg::OFS_PIN, wd, 33'h0);
		rd(ppo_pkg::OFS_OUT, {24'h0, out_s});
		drive_pins(1'b1);
		$display("test toggle done");
		apb(1'b1, 8'h14, 32'hffff_ffff, {1'b1, 32'h0});
		apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
		rd(ppo_pkg::OFS_DIR, {24'h0, dir_s});
		$display("test unmapped done");
		fork
			rd(ppo_pkg::OFS_PUE, {24'h0, pue_s});
			begin
				repeat (2) @(posedge pclk);
				pclken <= 1'b0;
				repeat (3) @(posedge pclk);
				pclken <= 1'b1;
			end
		join
		$display("test stretched access done");
		tally_and_finish();
	end
endmodule // ppo_port_top_tb
